// ### lvp_postprocess.sv
// Top of the loop vehicle post-processing block: smoothing settings,
// length correction and wrong-way evaluation of vehicle records.
// Assumes all inputs are synchronous to clock_in and channel indices
// stay below NUM_CH.
`timescale 1ns/1ps
module lvp_postprocess #(
    parameter int NUM_CH = 4,
    parameter int CH_W = 2,
    parameter int SAMPLE_W = 16,
    parameter int CNT_W = 8,
    parameter int CYCLE_W = 16,
    parameter int LEN_W = 12,
    parameter int SPEED_W = 8,
    // Default corrections in dm, loop type 0 in the low five bits
    parameter logic [19:0] CORR_DEFAULTS = 20'h00000
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic smooth_wr_in,
    input wire logic [CH_W-1:0] smooth_wr_channel_in,
    input wire logic [7:0] smooth_wr_steps_in,
    input wire logic [CYCLE_W-1:0] cycle_time_us_in,
    output logic [CYCLE_W-1:0] cycle_time_us_out,
    input wire logic sample_valid_in,
    input wire logic [CH_W-1:0] sample_channel_in,
    input wire logic [SAMPLE_W-1:0] sample_value_in,
    output logic smoothed_valid_out,
    output logic [CH_W-1:0] smoothed_channel_out,
    output logic [SAMPLE_W-1:0] smoothed_value_out,
    input wire logic corr_wr_in,
    input wire logic [4:0] corr_wr_dm_in,
    input wire logic corr_load_default_in,
    input wire logic [1:0] loop_type_in,
    output logic [4:0] corr_dm_out,
    input wire lvp_pkg::lvp_dir_mode_type dir_mode_in,
    input wire logic min_speed_wr_in,
    input wire logic [SPEED_W-1:0] min_speed_kmh_in,
    input wire logic vehicle_valid_in,
    input wire logic [LEN_W-1:0] atten_length_dm_in,
    input wire logic travel_dir_in,
    input wire logic [SPEED_W-1:0] speed_kmh_in,
    output logic vehicle_valid_out,
    output logic [LEN_W-1:0] real_length_dm_out,
    output logic wrong_way_flag_out,
    output logic reverse_direction_tag_out,
    output logic normal_direction_tag_out,
    output logic travel_digit_out
);

    typedef struct packed {
        logic [NUM_CH-1:0][7:0] smooth;
        logic [4:0] corr;
        logic [SPEED_W-1:0] min_speed;
        logic [CYCLE_W-1:0] cycle_time;
        logic veh_valid;
        logic [LEN_W-1:0] real_length;
        logic wrong_way;
        logic digit;
    } lvp_top_state_type;

    lvp_top_state_type st;
    lvp_top_state_type next_st;
    logic reverse_travel;
    logic ww_now;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Clamp a requested correction to the legal decimetre range
    function automatic logic [4:0] clamp_corr(input logic [4:0] dm);
        if (dm > lvp_pkg::CORR_MAX_DM) begin
            return lvp_pkg::CORR_MAX_DM;
        end
        return dm;
    endfunction

    // Samples to average: smoothing duration over the cycle time
    function automatic logic [CNT_W-1:0] avg_count(
        input logic [7:0] steps,
        input logic [CYCLE_W-1:0] cycle_us
    );
        int n;
        n = 0;
        if (cycle_us != '0) begin
            n = (int'(steps) * lvp_pkg::SMOOTH_STEP_US) / int'(cycle_us);
        end
        if (n > (2 ** CNT_W) - 1) begin
            n = (2 ** CNT_W) - 1;
        end
        return CNT_W'(n);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Averager hookup

    lvp_avg_if #(
        .CH_W(CH_W),
        .SAMPLE_W(SAMPLE_W),
        .CNT_W(CNT_W)
    ) avg_bus ();

    // Count follows the channel's setting and the live cycle time
    assign avg_bus.in_valid = sample_valid_in;
    assign avg_bus.in_channel = sample_channel_in;
    assign avg_bus.in_value = sample_value_in;
    assign avg_bus.in_count =
        avg_count(st.smooth[sample_channel_in], cycle_time_us_in);

    lvp_averager #(
        .NUM_CH(NUM_CH),
        .CH_W(CH_W),
        .SAMPLE_W(SAMPLE_W),
        .CNT_W(CNT_W)
    ) u_averager (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .avg(avg_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Direction decode
    always_comb begin
        case (dir_mode_in)
            lvp_pkg::LVP_DIR_FIRST_TO_SECOND: begin
                reverse_travel =
                    travel_dir_in == lvp_pkg::DIGIT_SECOND_TO_FIRST;
            end
            lvp_pkg::LVP_DIR_SECOND_TO_FIRST: begin
                reverse_travel =
                    travel_dir_in == lvp_pkg::DIGIT_FIRST_TO_SECOND;
            end
            default: begin
                reverse_travel = 1'b0;
            end
        endcase
        // Slow reverse vehicles raise no message
        ww_now = reverse_travel && (speed_kmh_in >= st.min_speed);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: settings and vehicle record
    always_comb begin
        next_st = st;
        next_st.veh_valid = 1'b0;
        next_st.cycle_time = cycle_time_us_in;
        if (smooth_wr_in) begin
            // Steps of 10 ms, held to the 100 ms ceiling
            if (smooth_wr_steps_in > lvp_pkg::SMOOTH_MAX_STEPS) begin
                next_st.smooth[smooth_wr_channel_in] =
                    lvp_pkg::SMOOTH_MAX_STEPS;
            end else begin
                next_st.smooth[smooth_wr_channel_in] = smooth_wr_steps_in;
            end
        end
        if (corr_load_default_in) begin
            // Default for the selected loop type, clamped
            next_st.corr = clamp_corr(CORR_DEFAULTS[loop_type_in * 5 +: 5]);
        end else if (corr_wr_in) begin
            next_st.corr = clamp_corr(corr_wr_dm_in);
        end
        if (min_speed_wr_in) begin
            next_st.min_speed = min_speed_kmh_in;
        end
        if (vehicle_valid_in) begin
            next_st.veh_valid = 1'b1;
            // Subtract correction, floor at zero
            if (atten_length_dm_in > LEN_W'(st.corr)) begin
                next_st.real_length = atten_length_dm_in - LEN_W'(st.corr);
            end else begin
                next_st.real_length = '0;
            end
            next_st.wrong_way = ww_now;
            next_st.digit = travel_dir_in;
        end
    end

    // State register; smoothing off and default correction after reset
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
            st.smooth <= {NUM_CH{lvp_pkg::SMOOTH_RESET}};
            st.corr <= CORR_DEFAULTS[4:0];
            st.min_speed <= SPEED_W'(lvp_pkg::MIN_SPEED_RESET);
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign cycle_time_us_out = st.cycle_time;
    assign smoothed_valid_out = avg_bus.out_valid;
    assign smoothed_channel_out = avg_bus.out_channel;
    assign smoothed_value_out = avg_bus.out_value;
    assign corr_dm_out = st.corr;
    assign vehicle_valid_out = st.veh_valid;
    assign real_length_dm_out = st.real_length;
    assign wrong_way_flag_out = st.wrong_way;
    assign reverse_direction_tag_out = st.wrong_way;
    assign normal_direction_tag_out = ~st.wrong_way;
    assign travel_digit_out = st.digit;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_cycle_time_shown: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        ##1 cycle_time_us_out == $past(cycle_time_us_in))
        else $error("Cycle time diagnostic is stale");

    chk_smooth_ceiling: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        smooth_wr_in && smooth_wr_steps_in > lvp_pkg::SMOOTH_MAX_STEPS
        |=> st.smooth[$past(smooth_wr_channel_in)] ==
            lvp_pkg::SMOOTH_MAX_STEPS)
        else $error("Smoothing duration not clamped");

    chk_zero_smooth_raw: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        sample_valid_in && st.smooth[sample_channel_in] == 8'h00
        |=> smoothed_valid_out && smoothed_value_out ==
            $past(sample_value_in))
        else $error("Zero smoothing did not pass raw value");

    chk_avg_count: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        cycle_time_us_in == 16'h1770 && st.smooth[sample_channel_in] ==
            8'h02 |-> avg_bus.in_count == 8'h03)
        else $error("Average count not duration over cycle time");

    chk_real_length: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        vehicle_valid_in && atten_length_dm_in > LEN_W'(st.corr)
        |=> vehicle_valid_out && real_length_dm_out ==
            $past(atten_length_dm_in) - LEN_W'($past(st.corr)))
        else $error("Real length wrong");

    chk_corr_range: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        corr_dm_out <= lvp_pkg::CORR_MAX_DM)
        else $error("Length correction above range");

    chk_default_load: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        corr_load_default_in |=> corr_dm_out ==
            clamp_corr(CORR_DEFAULTS[$past(loop_type_in) * 5 +: 5]))
        else $error("Default correction not loaded");

    chk_wrong_way_set: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        vehicle_valid_in && dir_mode_in == lvp_pkg::LVP_DIR_FIRST_TO_SECOND
        && travel_dir_in && speed_kmh_in >= st.min_speed
        |=> wrong_way_flag_out && reverse_direction_tag_out)
        else $error("Wrong-way flag missing");

    chk_dir_off_quiet: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        vehicle_valid_in && dir_mode_in == lvp_pkg::LVP_DIR_OFF
        |=> !wrong_way_flag_out && normal_direction_tag_out)
        else $error("Wrong-way raised with evaluation off");

    chk_travel_digit: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        vehicle_valid_in |=> travel_digit_out == $past(travel_dir_in))
        else $error("Travel digit wrong");

    chk_slow_reverse: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        vehicle_valid_in && speed_kmh_in < st.min_speed
        |=> !wrong_way_flag_out)
        else $error("Slow reverse vehicle flagged");

endmodule

// ### lvp_pkg.sv
// Constants and types for the loop vehicle post-processing block.
// Assumes one 50 MHz clock; all settings arrive as plain ports.
// Summary of operation
// - Smoothing duration is set per channel in steps of 10 ms.
// - Average count is duration over cycle time; output their arithmetic mean.
// - Smoothing duration is clamped to at most 100 ms.
// - After reset smoothing is zero, raw values pass through.
// - Current measurement cycle time is readable as a diagnostic value.
// - Real length is attenuation length minus the length correction.
// - Length correction is limited to 0 to 20 whole decimetres; reset loads CORR_DEFAULTS[4:0] unclamped.
// - A default length correction is loaded depending on loop type.
// - Wrong-way flag set only for travel opposite the normal direction.
// - Direction evaluation off keeps wrong-way flag inactive; readout tags normal.
// - Readout tags normal or reverse; digit 0 means first to second.
// - Reverse vehicles below minimum speed raise no wrong-way message.
package lvp_pkg;

    // Smoothing timing, in milliseconds and microseconds
    localparam int SMOOTH_STEP_MS = 10;
    localparam int SMOOTH_MAX_MS = 100;
    localparam int US_PER_MS = 1000;
    localparam int SMOOTH_STEP_US = SMOOTH_STEP_MS * US_PER_MS;
    localparam logic [7:0] SMOOTH_MAX_STEPS =
        8'(SMOOTH_MAX_MS / SMOOTH_STEP_MS);
    localparam logic [7:0] SMOOTH_RESET = 8'h00;

    // Length correction and wrong-way settings
    localparam logic [4:0] CORR_MAX_DM = 5'h14;
    localparam int CORR_W = 5;
    localparam int LOOP_TYPE_W = 2;
    localparam logic [7:0] MIN_SPEED_RESET = 8'h14;

    // Travel direction digit as shown on the service readout
    localparam logic DIGIT_FIRST_TO_SECOND = 1'b0;
    localparam logic DIGIT_SECOND_TO_FIRST = 1'b1;

    // Normal direction setting of the double loop system
    typedef enum logic [1:0] {
        LVP_DIR_OFF,
        LVP_DIR_FIRST_TO_SECOND,
        LVP_DIR_SECOND_TO_FIRST
    } lvp_dir_mode_type;

endpackage

// ### lvp_avg_if.sv
// Interface carrying samples into the averager and means back out.
// Assumes producer and averager share clock_in.
`timescale 1ns/1ps
interface lvp_avg_if #(
    parameter int CH_W = 2,
    parameter int SAMPLE_W = 16,
    parameter int CNT_W = 8
);
    logic in_valid;
    logic [CH_W-1:0] in_channel;
    logic [SAMPLE_W-1:0] in_value;
    logic [CNT_W-1:0] in_count;
    logic out_valid;
    logic [CH_W-1:0] out_channel;
    logic [SAMPLE_W-1:0] out_value;

    modport producer (
        output in_valid, in_channel, in_value, in_count,
        input out_valid, out_channel, out_value
    );
    modport averager (
        input in_valid, in_channel, in_value, in_count,
        output out_valid, out_channel, out_value
    );
endinterface

// ### lvp_averager.sv
// Per-channel block averager for measured loop values.
// Assumes the producer supplies the average count with each sample.
`timescale 1ns/1ps
module lvp_averager #(
    parameter int NUM_CH = 4,
    parameter int CH_W = 2,
    parameter int SAMPLE_W = 16,
    parameter int CNT_W = 8
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    lvp_avg_if.averager avg
);
    localparam int ACC_W = SAMPLE_W + CNT_W;

    typedef struct packed {
        logic [NUM_CH-1:0][ACC_W-1:0] acc;
        logic [NUM_CH-1:0][CNT_W-1:0] cnt;
        logic out_valid;
        logic [CH_W-1:0] out_channel;
        logic [SAMPLE_W-1:0] out_value;
    } lvp_avg_state_type;

    lvp_avg_state_type st;
    lvp_avg_state_type next_st;

    ////////////////////////////////////////////////////////////////////////
    // Accumulate until the count is reached, then emit the mean
    always_comb begin
        logic [ACC_W-1:0] sum;
        logic [CNT_W:0] filled;
        sum = st.acc[avg.in_channel] + ACC_W'(avg.in_value);
        filled = {1'b0, st.cnt[avg.in_channel]} + {{CNT_W{1'b0}}, 1'b1};
        next_st = st;
        next_st.out_valid = 1'b0;
        if (avg.in_valid) begin
            next_st.out_channel = avg.in_channel;
            if (avg.in_count <= CNT_W'(1)) begin
                // No smoothing: raw value goes straight through
                next_st.out_valid = 1'b1;
                next_st.out_value = avg.in_value;
                next_st.acc[avg.in_channel] = '0;
                next_st.cnt[avg.in_channel] = '0;
            end else if (filled >= {1'b0, avg.in_count}) begin
                // Arithmetic mean, fraction dropped
                next_st.out_valid = 1'b1;
                next_st.out_value =
                    SAMPLE_W'(sum / ACC_W'(avg.in_count));
                next_st.acc[avg.in_channel] = '0;
                next_st.cnt[avg.in_channel] = '0;
            end else begin
                next_st.acc[avg.in_channel] = sum;
                next_st.cnt[avg.in_channel] = filled[CNT_W-1:0];
            end
        end
    end

    // State register
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state
    assign avg.out_valid = st.out_valid;
    assign avg.out_channel = st.out_channel;
    assign avg.out_value = st.out_value;

    // Unsmoothed samples reappear unchanged one cycle later
    chk_raw_pass_through: assert property (
        @(posedge clock_in) disable iff (!arst_n_in)
        avg.in_valid && avg.in_count <= CNT_W'(1)
        |=> avg.out_valid && avg.out_value == $past(avg.in_value))
        else $error("Unsmoothed sample was not passed through");

endmodule

// ### lvp_loop_model.sv
// Model of the loops and record source feeding the post-processing block.
// Assumes one clock; tasks are called from the bench and return just
// after the edge that takes the request, with outputs settled.
`timescale 1ns/1ps
module lvp_loop_model #(
    parameter int CH_W = 2,
    parameter int SAMPLE_W = 16,
    parameter int LEN_W = 12,
    parameter int SPEED_W = 8
) (
    input wire logic clock_in,
    output logic sample_valid_out,
    output logic [CH_W-1:0] sample_channel_out,
    output logic [SAMPLE_W-1:0] sample_value_out,
    output logic vehicle_valid_out,
    output logic [LEN_W-1:0] atten_length_dm_out,
    output logic travel_dir_out,
    output logic [SPEED_W-1:0] speed_kmh_out
);
    ////////////////////////////////////////////////////////////////////////
    // Idle state at time zero
    initial begin
        sample_valid_out = 1'b0;
        sample_channel_out = '0;
        sample_value_out = '0;
        vehicle_valid_out = 1'b0;
        atten_length_dm_out = '0;
        travel_dir_out = 1'b0;
        speed_kmh_out = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One measured value; data inverted after release so nothing stale
    task automatic send_sample(input logic [CH_W-1:0] ch,
                               input logic [SAMPLE_W-1:0] val);
        @(posedge clock_in);
        sample_valid_out <= 1'b1;
        sample_channel_out <= ch;
        sample_value_out <= val;
        @(posedge clock_in);
        sample_valid_out <= 1'b0;
        sample_channel_out <= ~ch;
        sample_value_out <= ~val;
        #1;
    endtask

    // One vehicle record from the double loop
    task automatic send_vehicle(input logic [LEN_W-1:0] len,
                                input logic dir,
                                input logic [SPEED_W-1:0] spd);
        @(posedge clock_in);
        vehicle_valid_out <= 1'b1;
        atten_length_dm_out <= len;
        travel_dir_out <= dir;
        speed_kmh_out <= spd;
        @(posedge clock_in);
        vehicle_valid_out <= 1'b0;
        atten_length_dm_out <= ~len;
        travel_dir_out <= ~dir;
        speed_kmh_out <= ~spd;
        #1;
    endtask
endmodule

// ### test_loop_vehicle_postprocess.sv
// Self-checking bench for the loop vehicle post-processing block.
// Assumes the loop model above drives samples and vehicle records.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin failures++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module test_loop_vehicle_postprocess;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic smooth_wr_in = 1'b0, corr_wr_in = 1'b0, min_speed_wr_in = 1'b0;
    logic corr_load_default_in = 1'b0;
    logic [1:0] smooth_wr_channel_in = 2'h0, loop_type_in = 2'h0;
    logic [7:0] smooth_wr_steps_in = 8'h00, min_speed_kmh_in = 8'h00;
    logic [15:0] cycle_time_us_in = 16'h0000;
    logic [4:0] corr_wr_dm_in = 5'h00;
    lvp_pkg::lvp_dir_mode_type dir_mode_in = lvp_pkg::LVP_DIR_OFF;
    logic s_valid, s_dir, v_valid, sm_valid, v_out, ww, rtag, ntag, digit;
    logic [1:0] s_ch, sm_ch;
    logic [15:0] s_val, sm_val, cyc_out;
    logic [11:0] atten, real_len;
    logic [7:0] speed;
    logic [4:0] corr_out;
    int failures = 0;
    int samples_checked = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and loop model
    initial forever #10 clock_in = ~clock_in;
    lvp_postprocess #(.CORR_DEFAULTS(20'hCD0E3)) DUT (
        .clock_in(clock_in), .arst_n_in(arst_n_in),
        .smooth_wr_in(smooth_wr_in),
        .smooth_wr_channel_in(smooth_wr_channel_in),
        .smooth_wr_steps_in(smooth_wr_steps_in),
        .cycle_time_us_in(cycle_time_us_in), .cycle_time_us_out(cyc_out),
        .sample_valid_in(s_valid), .sample_channel_in(s_ch),
        .sample_value_in(s_val), .smoothed_valid_out(sm_valid),
        .smoothed_channel_out(sm_ch), .smoothed_value_out(sm_val),
        .corr_wr_in(corr_wr_in), .corr_wr_dm_in(corr_wr_dm_in),
        .corr_load_default_in(corr_load_default_in),
        .loop_type_in(loop_type_in), .corr_dm_out(corr_out),
        .dir_mode_in(dir_mode_in), .min_speed_wr_in(min_speed_wr_in),
        .min_speed_kmh_in(min_speed_kmh_in), .vehicle_valid_in(v_valid),
        .atten_length_dm_in(atten), .travel_dir_in(s_dir),
        .speed_kmh_in(speed), .vehicle_valid_out(v_out),
        .real_length_dm_out(real_len), .wrong_way_flag_out(ww),
        .reverse_direction_tag_out(rtag), .normal_direction_tag_out(ntag),
        .travel_digit_out(digit));
    lvp_loop_model PM (
        .clock_in(clock_in), .sample_valid_out(s_valid),
        .sample_channel_out(s_ch), .sample_value_out(s_val),
        .vehicle_valid_out(v_valid), .atten_length_dm_out(atten),
        .travel_dir_out(s_dir), .speed_kmh_out(speed));

    ////////////////////////////////////////////////////////////////////////
    // Closing report
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clock_in);
        failures++;
        print_verdict();
    end

    // Setting writes: one pulse, effective from the next cycle
    task automatic set_smooth(input logic [1:0] ch, input logic [7:0] st,
                              input logic [15:0] cyc);
        @(posedge clock_in);
        smooth_wr_in <= 1'b1;
        smooth_wr_channel_in <= ch;
        smooth_wr_steps_in <= st;
        cycle_time_us_in <= cyc;
        @(posedge clock_in);
        smooth_wr_in <= 1'b0;
        #1;
    endtask

    task automatic set_corr(input logic ld, input logic [4:0] v);
        @(posedge clock_in);
        corr_load_default_in <= ld;
        corr_wr_in <= ~ld;
        corr_wr_dm_in <= v;
        loop_type_in <= v[1:0];
        @(posedge clock_in);
        corr_load_default_in <= 1'b0;
        corr_wr_in <= 1'b0;
        #1;
    endtask

    // Sample with expected answer (ev: output pulse expected)
    task automatic smp(input logic [1:0] ch, input logic [15:0] v,
                       input logic ev, input logic [15:0] m);
        PM.send_sample(ch, v);
        `CHK("smoothed_valid", ev, sm_valid)
        if (ev) begin
            `CHK("smoothed_value", m, sm_val)
            `CHK("smoothed_channel", ch, sm_ch)
        end
    endtask

    // Vehicle with expected length and wrong-way result
    task automatic veh(input logic [11:0] len, input logic d,
                       input logic [7:0] sp, input logic [11:0] el,
                       input logic ew);
        PM.send_vehicle(len, d, sp);
        `CHK("vehicle_valid", 1'b1, v_out)
        `CHK("real_length", el, real_len)
        `CHK("wrong_way", ew, ww)
        `CHK("reverse_tag", ew, rtag)
        `CHK("normal_tag", ~ew, ntag)
        `CHK("travel_digit", d, digit)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset();
        `CHK("corr_reset", 5'h03, corr_out)
        `CHK("normal_tag_reset", 1'b1, ntag)
        `CHK("valid_reset", 1'b0, v_out)
        $display("test_reset done");
    endtask

    task automatic test_smoothing();
        cycle_time_us_in <= 16'h1770;
        smp(2'h0, 16'h0007, 1'b1, 16'h0007);
        `CHK("cycle_time", 16'h1770, cyc_out)
        set_smooth(2'h1, 8'h02, 16'h1770);
        smp(2'h1, 16'h000A, 1'b0, 16'h0000);
        smp(2'h0, 16'h0009, 1'b1, 16'h0009);
        smp(2'h1, 16'h000B, 1'b0, 16'h0000);
        smp(2'h1, 16'h000D, 1'b1, 16'h000B);
        set_smooth(2'h1, 8'hC8, 16'hC350);
        smp(2'h1, 16'h0004, 1'b0, 16'h0000);
        smp(2'h1, 16'h0006, 1'b1, 16'h0005);
        set_smooth(2'h1, 8'h01, 16'h2710);
        smp(2'h1, 16'h0021, 1'b1, 16'h0021);
        $display("test_smoothing done");
    endtask

    task automatic test_length();
        dir_mode_in <= lvp_pkg::LVP_DIR_OFF;
        veh(12'h02D, 1'b0, 8'h32, 12'h02A, 1'b0);
        set_corr(1'b0, 5'h19);
        `CHK("corr_clamp", 5'h14, corr_out)
        set_corr(1'b1, 5'h01);
        `CHK("corr_default1", 5'h07, corr_out)
        set_corr(1'b1, 5'h02);
        `CHK("corr_default2", 5'h14, corr_out)
        set_corr(1'b0, 5'h07);
        `CHK("corr_write", 5'h07, corr_out)
        set_corr(1'b1, 5'h03);
        `CHK("corr_default3", 5'h14, corr_out)
        set_corr(1'b1, 5'h01);
        `CHK("corr_default1b", 5'h07, corr_out)
        veh(12'h02D, 1'b1, 8'h32, 12'h026, 1'b0);
        $display("test_length done");
    endtask

    task automatic test_direction();
        logic e;
        for (int m = 0; m < 4; m++) begin
            for (int d = 0; d < 2; d++) begin
                e = (m == 1 && d == 1) || (m == 2 && d == 0);
                dir_mode_in <= lvp_pkg::lvp_dir_mode_type'(m);
                veh(12'h050, d[0], 8'h32, 12'h049, e);
            end
        end
        $display("test_direction done");
    endtask

    task automatic test_min_speed();
        dir_mode_in <= lvp_pkg::LVP_DIR_FIRST_TO_SECOND;
        veh(12'h050, 1'b1, 8'h13, 12'h049, 1'b0);
        veh(12'h050, 1'b1, 8'h14, 12'h049, 1'b1);
        @(posedge clock_in);
        min_speed_wr_in <= 1'b1;
        min_speed_kmh_in <= 8'h28;
        @(posedge clock_in);
        min_speed_wr_in <= 1'b0;
        veh(12'h050, 1'b1, 8'h27, 12'h049, 1'b0);
        veh(12'h050, 1'b1, 8'h28, 12'h049, 1'b1);
        veh(12'h050, 1'b0, 8'h27, 12'h049, 1'b0);
        $display("test_min_speed done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge clock_in);
        #1;
        test_reset();
        @(posedge clock_in);
        arst_n_in <= 1'b1;
        test_smoothing();
        test_length();
        test_direction();
        test_min_speed();
        print_verdict();
    end
endmodule
